// [design/pid_pkg.sv]
package pid_pkg;
  localparam int DATA_W       = 16;
  localparam int ACC_W        = 40;
  localparam int ADDR_W       = 8;
  localparam int SHIFT_W      = 6;
  localparam int DL_LEN       = 3;
  localparam int CF_LEN       = 4;
  localparam int SETUP_CYCLES = 7;
  localparam logic [1:0] STEP = 2'h1;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] ERROR_OFF  = 8'h08;
  localparam logic [7:0] SCALE_OFF  = 8'h0c;
  localparam logic [7:0] OUTPUT_OFF = 8'h10;
  localparam logic [7:0] PTR_OFF    = 8'h14;
  localparam logic [7:0] COEFF_OFF  = 8'h20;
  localparam logic [7:0] DELAY_OFF  = 8'h30;
  // Field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_SLOW_BIT  = 1;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_DONE_BIT    = 1;
  localparam int ST_SETUP_BIT   = 2;
  localparam int PTR_CF_POS     = 8;
  // Reset values, rounding bias and bus response codes
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [SHIFT_W-1:0] SHIFT_RST = 6'h00;
  localparam logic [1:0]        PTR_RST  = 2'h0;
  localparam logic [ACC_W-1:0]  ROUND_BIAS = 40'h0000008000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axi_rsp_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_FETCH, ST_MAC_A2, ST_MAC_A1, ST_MAC_A0, ST_MAC_B,
    ST_SHIFT, ST_STORE
  } state_t;
endpackage

// [design/pid_control_datapath.sv]
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - U(n) = B*U(n-1) + A0*E(n) + A1*E(n-1) + A2*E(n-2).
// - Output register takes upper half of shifted accumulator at the end.
// - Scale factor in shift register; high accumulator word shifted arithmetically.
// - E(n-2), E(n-1), U(n-1) kept in wrapping delay line of three.
// - Delay line holds zeros after reset unless software loads values.
// - Four coefficients A2, A1, A0, B stored circularly, step one.
// - All values 1.15 signed fractions; products signed by signed.
// - Accumulate in stored order; round on the final B product.
// - Two pointers fetch operands in the same cycles as the MACs.
// - Delay line rewritten with old E(n-1), E(n), then U(n).
// - Computation takes 7 cycles fast or 11 cycles slow.
// - SETUP_COUNT setup cycles (7 by default, up to 15) after pointer or scale settings change.
// - Result follows incremental PID difference form.
module pid_control_datapath #(
  parameter int SETUP_COUNT = pid_pkg::SETUP_CYCLES
) (
  input  wire logic                          clk_in,
  input  wire logic                          rst_n_in,
  input  wire pid_pkg::axi_req_t             axi_req_in,
  output pid_pkg::axi_rsp_t                  axi_rsp_out,
  input  wire logic                          start_in,
  input  wire logic [pid_pkg::DATA_W-1:0]    error_in,
  output logic                               busy_out,
  output logic                               done_out,
  output logic [pid_pkg::DATA_W-1:0]         u_out
);
  localparam int DW = pid_pkg::DATA_W;
  localparam int AW = pid_pkg::ACC_W;

  if (SETUP_COUNT < 1 || SETUP_COUNT > 15) begin
    $error("SETUP_COUNT must be 1 to 15");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [1:0] bump(input logic [1:0] p, input int len);
    bump = (p == 2'(len - 1)) ? 2'h0 : p + pid_pkg::STEP;
  endfunction

  // Fractional product is shifted left once, as a 1.15 by 1.15 multiply
  function automatic logic [AW-1:0] mac(input logic [AW-1:0] acc,
                                        input logic [DW-1:0] a,
                                        input logic [DW-1:0] b);
    logic signed [2*DW-1:0] p;
    p   = $signed(a) * $signed(b);
    mac = acc + {{(AW-2*DW-1){p[2*DW-1]}}, p, 1'b0};
  endfunction

  function automatic logic [DW-1:0] scale_up(input logic [DW-1:0] hi,
                                             input logic [pid_pkg::SHIFT_W-1:0] amt);
    logic signed [2*DW-1:0] w;
    logic [pid_pkg::SHIFT_W-1:0] mag;
    w   = $signed({hi, 16'h0000});
    // Negative amounts scale down; bits pushed past the top simply wrap
    mag = amt[pid_pkg::SHIFT_W-1] ? (~amt + 6'h01) : amt;
    w   = amt[pid_pkg::SHIFT_W-1] ? (w >>> mag) : (w <<< mag);
    scale_up = w[2*DW-1:DW];
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) &&
              ((a <= pid_pkg::PTR_OFF) ||
               (a >= pid_pkg::COEFF_OFF && a < pid_pkg::DELAY_OFF + 8'h0c));
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = s[i] ? d[8*i +: 8] : old[8*i +: 8];
    end
    merge = old;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  logic                aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
  logic [7:0]          aw_addr_reg, aw_addr_next;
  logic [31:0]         w_data_reg, w_data_next;
  logic [3:0]          w_strb_reg, w_strb_next;
  logic                bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]          bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0]         rdata_reg, rdata_next, rd_word;
  logic                wr_en;

  // Core state
  pid_pkg::state_t     st_reg, st_next;
  logic                slow_reg, slow_next, hold_reg, hold_next;
  logic                dirty_reg, dirty_next, done_reg, done_next;
  logic                done_flag_reg, done_flag_next;
  logic [3:0]          setup_cnt_reg, setup_cnt_next;
  logic [DW-1:0]       err_reg, err_next, out_reg, out_next;
  logic [DW-1:0]       x0_reg, x0_next, x1_reg, x1_next, c_reg, c_next;
  logic [DW-1:0]       sr_reg, sr_next;
  logic [pid_pkg::SHIFT_W-1:0] scale_reg, scale_next;
  logic [1:0]          dp_reg, dp_next, cp_reg, cp_next;
  logic [AW-1:0]       acc_reg, acc_next;
  logic [DW-1:0]       dl_reg [pid_pkg::DL_LEN];
  logic [DW-1:0]       dl_next [pid_pkg::DL_LEN];
  logic [DW-1:0]       cf_reg [pid_pkg::CF_LEN];
  logic [DW-1:0]       cf_next [pid_pkg::CF_LEN];
  logic [31:0]         wv;
  logic                sw_start, idle, stall;

  assign wr_en = aw_hold_reg && w_hold_reg;
  assign idle  = (st_reg == pid_pkg::ST_IDLE);

  always_comb begin
    rd_word = 32'h0;
    unique case (axi_req_in.araddr)
      pid_pkg::CTRL_OFF:   rd_word[pid_pkg::CTRL_SLOW_BIT] = slow_reg;
      pid_pkg::STATUS_OFF: rd_word[2:0] = {dirty_reg, done_flag_reg, !idle};
      pid_pkg::ERROR_OFF:  rd_word[DW-1:0] = err_reg;
      pid_pkg::SCALE_OFF:  rd_word[pid_pkg::SHIFT_W-1:0] = scale_reg;
      pid_pkg::OUTPUT_OFF: rd_word[DW-1:0] = out_reg;
      pid_pkg::PTR_OFF:    rd_word = {22'h0, cp_reg, 6'h00, dp_reg};
      default: begin
        if (axi_req_in.araddr[7:4] == pid_pkg::COEFF_OFF[7:4]) begin
          rd_word[DW-1:0] = cf_reg[axi_req_in.araddr[3:2]];
        end else if (axi_req_in.araddr[7:4] == pid_pkg::DELAY_OFF[7:4] &&
                     axi_req_in.araddr[3:2] != 2'h3) begin
          rd_word[DW-1:0] = dl_reg[axi_req_in.araddr[3:2]];
        end
      end
    endcase
  end

  always_comb begin
    aw_hold_next = aw_hold_reg;
    aw_addr_next = aw_addr_reg;
    w_hold_next  = w_hold_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    if (axi_rsp_out.awready && axi_req_in.awvalid) begin
      aw_hold_next = 1'b1;
      aw_addr_next = axi_req_in.awaddr;
    end
    if (axi_rsp_out.wready && axi_req_in.wvalid) begin
      w_hold_next = 1'b1;
      w_data_next = axi_req_in.wdata;
      w_strb_next = axi_req_in.wstrb;
    end
    if (wr_en) begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = addr_ok(aw_addr_reg) ? pid_pkg::RESP_OKAY : pid_pkg::RESP_SLVERR;
    end else if (bvalid_reg && axi_req_in.bready) begin
      bvalid_next = 1'b0;
    end
    if (axi_rsp_out.arready && axi_req_in.arvalid) begin
      rvalid_next = 1'b1;
      rdata_next  = rd_word;
      rresp_next  = addr_ok(axi_req_in.araddr) ? pid_pkg::RESP_OKAY : pid_pkg::RESP_SLVERR;
    end else if (rvalid_reg && axi_req_in.rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_hold_reg  <= 1'b0;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= pid_pkg::RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= pid_pkg::RESP_OKAY;
      rdata_reg   <= 32'h0;
    end else begin
      aw_hold_reg <= aw_hold_next;
      aw_addr_reg <= aw_addr_next;
      w_hold_reg  <= w_hold_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign axi_rsp_out = '{awready: !aw_hold_reg && !bvalid_reg,
                         wready:  !w_hold_reg && !bvalid_reg,
                         bresp:   bresp_reg, bvalid: bvalid_reg,
                         arready: !rvalid_reg, rdata: rdata_reg,
                         rresp:   rresp_reg, rvalid: rvalid_reg};

  ////////////////////////////////////////////////////////////////////////////
  // Controller core
  always_comb begin
    st_next = st_reg;         slow_next = slow_reg;     hold_next = 1'b0;
    dirty_next = dirty_reg;   done_next = 1'b0;         done_flag_next = done_flag_reg;
    setup_cnt_next = setup_cnt_reg;
    err_next = err_reg;       out_next = out_reg;       sr_next = sr_reg;
    x0_next = x0_reg;         x1_next = x1_reg;         c_next = c_reg;
    scale_next = scale_reg;   dp_next = dp_reg;         cp_next = cp_reg;
    acc_next = acc_reg;       dl_next = dl_reg;         cf_next = cf_reg;
    sw_start = 1'b0;
    wv = 32'h0;
    // Register writes; array and pointer writes are dropped while busy
    if (wr_en) begin
      unique case (aw_addr_reg)
        pid_pkg::CTRL_OFF: begin
          wv = merge({30'h0, slow_reg, 1'b0}, w_data_reg, w_strb_reg);
          slow_next = wv[pid_pkg::CTRL_SLOW_BIT];
          sw_start  = wv[pid_pkg::CTRL_START_BIT];
        end
        pid_pkg::STATUS_OFF: begin
          wv = merge(32'h0, w_data_reg, w_strb_reg);
          if (wv[pid_pkg::ST_DONE_BIT]) done_flag_next = 1'b0;
        end
        pid_pkg::ERROR_OFF: begin
          wv = merge({16'h0, err_reg}, w_data_reg, w_strb_reg);
          err_next = wv[DW-1:0];
        end
        pid_pkg::SCALE_OFF: begin
          wv = merge({26'h0, scale_reg}, w_data_reg, w_strb_reg);
          scale_next = wv[pid_pkg::SHIFT_W-1:0];
          dirty_next = 1'b1;
        end
        pid_pkg::PTR_OFF: begin
          wv = merge({22'h0, cp_reg, 6'h00, dp_reg}, w_data_reg, w_strb_reg);
          if (idle) begin
            dp_next    = (wv[1:0] > 2'h2) ? 2'h0 : wv[1:0];
            cp_next    = wv[pid_pkg::PTR_CF_POS+1:pid_pkg::PTR_CF_POS];
            dirty_next = 1'b1;
          end
        end
        default: begin
          if (idle && aw_addr_reg[7:4] == pid_pkg::COEFF_OFF[7:4]) begin
            wv = merge({16'h0, cf_reg[aw_addr_reg[3:2]]}, w_data_reg, w_strb_reg);
            cf_next[aw_addr_reg[3:2]] = wv[DW-1:0];
          end else if (idle && aw_addr_reg[7:4] == pid_pkg::DELAY_OFF[7:4] &&
                       aw_addr_reg[3:2] != 2'h3) begin
            wv = merge({16'h0, dl_reg[aw_addr_reg[3:2]]}, w_data_reg, w_strb_reg);
            dl_next[aw_addr_reg[3:2]] = wv[DW-1:0];
          end
        end
      endcase
    end
    // Slow variant spends a second cycle in each multiply step
    stall = slow_reg && !hold_reg;
    unique case (st_reg)
      pid_pkg::ST_IDLE: begin
        if (start_in || sw_start) begin
          if (start_in) err_next = error_in;
          st_next = dirty_reg ? pid_pkg::ST_SETUP : pid_pkg::ST_FETCH;
          setup_cnt_next = 4'(SETUP_COUNT - 1);
        end
      end
      pid_pkg::ST_SETUP: begin
        setup_cnt_next = setup_cnt_reg - 4'h1;
        if (setup_cnt_reg == 4'h0) begin
          dirty_next = 1'b0;
          st_next    = pid_pkg::ST_FETCH;
        end
      end
      pid_pkg::ST_FETCH: begin
        x0_next = dl_reg[dp_reg];
        c_next  = cf_reg[cp_reg];
        dp_next = bump(dp_reg, pid_pkg::DL_LEN);
        cp_next = bump(cp_reg, pid_pkg::CF_LEN);
        st_next = pid_pkg::ST_MAC_A2;
      end
      pid_pkg::ST_MAC_A2: begin
        hold_next = stall;
        if (!stall) begin
          acc_next = mac('0, x0_reg, c_reg);
          x1_next  = dl_reg[dp_reg];
          c_next   = cf_reg[cp_reg];
          dp_next  = bump(dp_reg, pid_pkg::DL_LEN);
          cp_next  = bump(cp_reg, pid_pkg::CF_LEN);
          st_next  = pid_pkg::ST_MAC_A1;
        end
      end
      pid_pkg::ST_MAC_A1: begin
        hold_next = stall;
        if (!stall) begin
          acc_next = mac(acc_reg, x1_reg, c_reg);
          c_next   = cf_reg[cp_reg];
          cp_next  = bump(cp_reg, pid_pkg::CF_LEN);
          st_next  = pid_pkg::ST_MAC_A0;
        end
      end
      pid_pkg::ST_MAC_A0: begin
        hold_next = stall;
        if (!stall) begin
          acc_next = mac(acc_reg, err_reg, c_reg);
          x0_next  = dl_reg[dp_reg];
          c_next   = cf_reg[cp_reg];
          dp_next  = bump(dp_reg, pid_pkg::DL_LEN);
          cp_next  = bump(cp_reg, pid_pkg::CF_LEN);
          st_next  = pid_pkg::ST_MAC_B;
        end
      end
      pid_pkg::ST_MAC_B: begin
        hold_next = stall;
        if (!stall) begin
          // Rounding bias joins only the last product, at bit 15
          acc_next = mac(acc_reg, x0_reg, c_reg) + pid_pkg::ROUND_BIAS;
          dl_next[dp_reg] = x1_reg;
          dp_next = bump(dp_reg, pid_pkg::DL_LEN);
          st_next = pid_pkg::ST_SHIFT;
        end
      end
      pid_pkg::ST_SHIFT: begin
        sr_next = scale_up(acc_reg[2*DW-1:DW], scale_reg);
        dl_next[dp_reg] = err_reg;
        dp_next = bump(dp_reg, pid_pkg::DL_LEN);
        st_next = pid_pkg::ST_STORE;
      end
      pid_pkg::ST_STORE: begin
        dl_next[dp_reg] = sr_reg;
        dp_next = bump(dp_reg, pid_pkg::DL_LEN);
        out_next = sr_reg;
        done_next = 1'b1;
        done_flag_next = 1'b1;
        st_next = pid_pkg::ST_IDLE;
      end
      default: st_next = pid_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_reg        <= pid_pkg::ST_IDLE;
      slow_reg      <= 1'b0;
      hold_reg      <= 1'b0;
      dirty_reg     <= 1'b0;
      done_reg      <= 1'b0;
      done_flag_reg <= 1'b0;
      setup_cnt_reg <= 4'h0;
      err_reg       <= pid_pkg::DATA_RST;
      out_reg       <= pid_pkg::DATA_RST;
      sr_reg        <= pid_pkg::DATA_RST;
      x0_reg        <= pid_pkg::DATA_RST;
      x1_reg        <= pid_pkg::DATA_RST;
      c_reg         <= pid_pkg::DATA_RST;
      scale_reg     <= pid_pkg::SHIFT_RST;
      dp_reg        <= pid_pkg::PTR_RST;
      cp_reg        <= pid_pkg::PTR_RST;
      acc_reg       <= '0;
      dl_reg        <= '{default: pid_pkg::DATA_RST};
      cf_reg        <= '{default: pid_pkg::DATA_RST};
    end else begin
      st_reg        <= st_next;
      slow_reg      <= slow_next;
      hold_reg      <= hold_next;
      dirty_reg     <= dirty_next;
      done_reg      <= done_next;
      done_flag_reg <= done_flag_next;
      setup_cnt_reg <= setup_cnt_next;
      err_reg       <= err_next;
      out_reg       <= out_next;
      sr_reg        <= sr_next;
      x0_reg        <= x0_next;
      x1_reg        <= x1_next;
      c_reg         <= c_next;
      scale_reg     <= scale_next;
      dp_reg        <= dp_next;
      cp_reg        <= cp_next;
      acc_reg       <= acc_next;
      dl_reg        <= dl_next;
      cf_reg        <= cf_next;
    end
  end

  assign busy_out = !idle;
  assign done_out = done_reg;
  assign u_out    = out_reg;
endmodule

// [verification/pid_control_datapath_monitor.sv]
`timescale 1ns/1ps
module pid_control_datapath_monitor #(
  parameter int SETUP_COUNT = pid_pkg::SETUP_CYCLES
) (
  input wire logic                       clk_in,
  input wire logic                       rst_n_in,
  input wire pid_pkg::axi_req_t          axi_req_in,
  input wire pid_pkg::axi_rsp_t          axi_rsp_out,
  input wire logic                       start_in,
  input wire logic [pid_pkg::DATA_W-1:0] error_in,
  input wire logic                       busy_out,
  input wire logic                       done_out,
  input wire logic [pid_pkg::DATA_W-1:0] u_out
);
  // Slowest path is the slow variant plus the setup penalty
  localparam int LAT_MAX = 11 + SETUP_COUNT;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_done_pulse: assert property (done_out |=> !done_out)
    else $error("done_out held longer than one cycle");
  a_start_busy: assert property (start_in && !busy_out |=> busy_out)
    else $error("start while idle did not raise busy_out");
  a_done_idle: assert property (done_out |-> !busy_out && $past(busy_out))
    else $error("done_out not at the end of a busy period");
  a_busy_min: assert property ($rose(busy_out) |-> busy_out [*7])
    else $error("computation shorter than the fast variant");
  a_done_bound: assert property ($rose(busy_out) |-> ##[7:LAT_MAX] done_out)
    else $error("done_out missing within the allowed cycles");
  a_output_hold: assert property (!done_out |-> $stable(u_out))
    else $error("u_out changed without done_out");
  a_write_answer: assert property (axi_req_in.awvalid && axi_rsp_out.awready &&
    axi_req_in.wvalid && axi_rsp_out.wready |-> ##2 axi_rsp_out.bvalid)
    else $error("write response late");
  a_read_answer: assert property (axi_req_in.arvalid && axi_rsp_out.arready
    |=> axi_rsp_out.rvalid)
    else $error("read response late");
  a_bresp_hold: assert property (axi_rsp_out.bvalid && !axi_req_in.bready
    |=> axi_rsp_out.bvalid && $stable(axi_rsp_out.bresp))
    else $error("write response dropped before bready");
  a_rdata_hold: assert property (axi_rsp_out.rvalid && !axi_req_in.rready
    |=> axi_rsp_out.rvalid && $stable(axi_rsp_out.rdata))
    else $error("read data dropped before rready");
  a_read_block: assert property (axi_rsp_out.rvalid |-> !axi_rsp_out.arready)
    else $error("arready high while a read answer waits");
endmodule

bind pid_control_datapath pid_control_datapath_monitor #(.SETUP_COUNT(SETUP_COUNT)) monitor_i (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .axi_req_in(axi_req_in), .axi_rsp_out(axi_rsp_out),
  .start_in(start_in), .error_in(error_in), .busy_out(busy_out), .done_out(done_out),
  .u_out(u_out));

// [verification/pid_plant_model.sv]
`timescale 1ns/1ps
module pid_plant_model (
  input wire logic                        clk_in,
  input wire logic                        rst_n_in,
  input wire logic                        send_in,
  input wire logic [pid_pkg::DATA_W-1:0]  sample_in,
  input wire logic                        done_in,
  input wire logic [pid_pkg::DATA_W-1:0]  u_in,
  output logic                            start_out,
  output logic [pid_pkg::DATA_W-1:0]      error_out,
  output logic [pid_pkg::DATA_W-1:0]      dac_out
);
  // Sample is valid only with the start pulse; otherwise it keeps toggling
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      start_out <= 1'b0;
      error_out <= 16'h0000;
      dac_out   <= 16'h0000;
    end else begin
      start_out <= send_in;
      error_out <= send_in ? sample_in : ~error_out;
      if (done_in) begin
        dac_out <= u_in;
      end
    end
  end
endmodule

// [verification/pid_control_datapath_test.sv]
`timescale 1ns/1ps
module pid_control_datapath_test;
  localparam int SC = 3;
  logic              clk_in;
  logic              rst_n_in;
  pid_pkg::axi_req_t req;
  pid_pkg::axi_rsp_t rsp;
  logic              start_in, busy_out, done_out, send;
  logic [15:0]       error_in, u_out, dac, smp, u;
  logic [31:0]       d;
  logic [1:0]        r;
  logic [15:0]       dl [3];
  logic [15:0]       cf [4];
  logic [5:0]        sf;
  int                fail_count, tests_run, cyc, dp, cp, n;

  pid_control_datapath #(.SETUP_COUNT(SC)) pid_control_datapath_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .axi_req_in(req), .axi_rsp_out(rsp),
    .start_in(start_in), .error_in(error_in), .busy_out(busy_out), .done_out(done_out),
    .u_out(u_out));
  pid_plant_model pid_plant_model_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .send_in(send), .sample_in(smp),
    .done_in(done_out), .u_in(u_out), .start_out(start_in), .error_out(error_in),
    .dac_out(dac));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("Counts: %0d checks, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Ready sides are random so the hold-until-taken paths get exercised
  task automatic wr(logic [7:0] a, logic [31:0] v, output logic [1:0] rs);
    req.awaddr <= a; req.wdata <= v; req.wstrb <= 4'hf;
    req.awvalid <= 1'b1; req.wvalid <= 1'b1;
    forever begin
      @(posedge clk_in);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (req.bready && rsp.bvalid) begin
        rs = rsp.bresp; req.bready <= 1'b0; break;
      end
      if (!req.bready) req.bready <= 1'($urandom);
    end
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    req.araddr <= a; req.arvalid <= 1'b1;
    forever begin
      @(posedge clk_in);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (req.rready && rsp.rvalid) begin
        v = rsp.rdata; rs = rsp.rresp; req.rready <= 1'b0; break;
      end
      if (!req.rready) req.rready <= 1'($urandom);
    end
  endtask
  task automatic wreg(logic [7:0] a, logic [31:0] v);
    wr(a, v, r);
    chk("bresp", 32'(r), 32'(pid_pkg::RESP_OKAY));
  endtask
  task automatic rchk(string nm, logic [7:0] a, logic [31:0] exp);
    rd(a, d, r);
    chk(nm, d, exp);
    chk("rresp", 32'(r), 32'(pid_pkg::RESP_OKAY));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic signed [39:0] pr(logic [15:0] x, logic [15:0] y);
    logic signed [39:0] p;
    p = $signed(x);
    return (p * $signed(y)) <<< 1;
  endfunction
  function automatic logic [15:0] calc(logic [15:0] e2, e1, e0, u1, a2, a1, a0, b,
                                       logic [5:0] s);
    logic signed [39:0] acc;
    logic signed [31:0] w;
    acc = pr(e2, a2) + pr(e1, a1) + pr(e0, a0) + pr(u1, b) + 40'sh8000;
    w = {acc[31:16], 16'h0000};
    if (s[5]) w = w >>> (6'(~s) + 6'h1);
    else w = w <<< s;
    return w[31:16];
  endfunction
  // Circular history: oldest error, previous error, previous output
  task automatic predict(logic [15:0] e);
    u = calc(dl[dp], dl[(dp+1)%3], e, dl[(dp+2)%3], cf[cp], cf[(cp+1)%4],
             cf[(cp+2)%4], cf[(cp+3)%4], sf);
    dl[dp] = dl[(dp+1)%3];
    dl[(dp+1)%3] = e;
    dl[(dp+2)%3] = u;
  endtask
  task automatic run(logic [15:0] e, int lat, bit intr);
    predict(e);
    smp <= e; send <= 1'b1;
    @(posedge clk_in); send <= 1'b0;
    @(posedge clk_in);
    n = 0;
    do begin
      @(posedge clk_in); n++; send <= intr && n == 3;
      if (n == 1) chk("busy", 32'(busy_out), 32'h1);
    end while (!done_out && n < 60);
    chk("u_out", 32'(u_out), 32'(u));
    chk("idle", 32'(busy_out), 32'h0);
    // Edges counted from the start edge to the one that samples done high
    chk("latency", n, lat);
    @(posedge clk_in);
    chk("dac", 32'(dac), 32'(u));
    if (intr) begin
      n = 0;
      repeat (14) begin
        @(posedge clk_in); if (done_out) n++;
      end
      chk("extra_done", n, 0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    req = '0; rst_n_in = 1'b0; send = 1'b0; smp = 16'h0000; sf = 6'h00;
    fail_count = 0; tests_run = 0; cyc = 0; dp = 0; cp = 0;
    dl = '{default: 16'h0000}; cf = '{default: 16'h0000};
    void'($urandom(32'hfab324be));
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    for (int i = 0; i < 3; i++) rchk("delay_rst", pid_pkg::DELAY_OFF + 8'(4*i), 0);
    rchk("output_rst", pid_pkg::OUTPUT_OFF, 0);
    rchk("status_rst", pid_pkg::STATUS_OFF, 0);
    rd(8'h1c, d, r);
    chk("unmapped_data", d, 0);
    chk("unmapped_resp", 32'(r), 32'(pid_pkg::RESP_SLVERR));
    wr(8'h09, 32'h5, r);
    chk("unaligned_resp", 32'(r), 32'(pid_pkg::RESP_SLVERR));
    $display("Test reset and decode done");
    for (int k = 0; k < 3; k++) begin
      sf = (k == 2) ? 6'h3f : 6'(k + 1);
      dp = $urandom % 3;
      cp = $urandom % 4;
      for (int j = 0; j < 3; j++) cf[(cp+j)%4] = 16'($signed(16'($urandom)) >>> 3);
      cf[(cp+3)%4] = sf[5] ? 16'h7fff : 16'(32'h8000 >> sf);
      wreg(pid_pkg::SCALE_OFF, 32'(sf));
      wreg(pid_pkg::PTR_OFF, 32'(dp) | (32'(cp) << pid_pkg::PTR_CF_POS));
      for (int j = 0; j < 4; j++) wreg(pid_pkg::COEFF_OFF + 8'(4*j), 32'(cf[j]));
      for (int j = 0; j < 4; j++) run(16'($urandom), j == 0 ? 8 + SC : 8, 1'b0);
      for (int j = 0; j < 3; j++) rchk("delay", pid_pkg::DELAY_OFF + 8'(4*j), 32'(dl[j]));
      $display("Test scale setting %0d done", k);
    end
    wreg(pid_pkg::CTRL_OFF, 32'h2);
    run(16'h8000, 12, 1'b1);
    rchk("status_done", pid_pkg::STATUS_OFF, 32'h2);
    wreg(pid_pkg::STATUS_OFF, 32'h2);
    rchk("status_clear", pid_pkg::STATUS_OFF, 32'h0);
    $display("Test slow variant done");
    predict(16'h7fff);
    wreg(pid_pkg::ERROR_OFF, 32'h7fff);
    wreg(pid_pkg::CTRL_OFF, 32'h3);
    n = 0;
    while (!done_out && n < 60) begin
      @(posedge clk_in); n++;
    end
    chk("u_out_reg_start", 32'(u_out), 32'(u));
    $display("Test register start done");
    conclude();
  end
endmodule
